// >>> design/plp_pipeline.sv
`timescale 1ns/10ps
// Summary of operation
// - host pixel data goes into pixel buffer
// - update with execute copies pixels to frame
// - strip output only on send or cyclic
// - command mode takes one command per execute
// - one fill command covers its start-and-count span, up to whole buffer
// - extended mode writes eight-pixel segment per execute
// - 24 or 32 bits, then reset gap
// - pixel writes and sending run concurrently
// - all selected data channels written together, clock lane of a clocked group skipped
// - channels transfer and send independently
// - two groups of two channels
// - group: two async lines or data+clock
// - group change restores its settings defaults
// - restore honoured only in pre-operational state
// - lanes follow group configuration automatically
// - cyclic resend every 250 ms when enabled
module plp_pipeline #(
    parameter int NPIX          = plp_pkg::NPIX,      // pixels per channel
    parameter int CYCLIC_CYCLES = plp_pkg::CYCLIC_CYC // cyclic resend period
) (
    input  wire logic        MCLK,    // 10 MHz clock
    input  wire logic        RESETN,  // async reset, low
    input  wire logic [7:0]  AWADDR,  // write address
    input  wire logic        AWVALID, // write address valid
    output logic             AWREADY, // write address ready
    input  wire logic [31:0] WDATA,   // write data
    input  wire logic [3:0]  WSTRB,   // byte enables
    input  wire logic        WVALID,  // write data valid
    output logic             WREADY,  // write data ready
    output logic [1:0]       BRESP,   // write response
    output logic             BVALID,  // write response valid
    input  wire logic        BREADY,  // write response ready
    input  wire logic [7:0]  ARADDR,  // read address
    input  wire logic        ARVALID, // read address valid
    output logic             ARREADY, // read address ready
    output logic [31:0]      RDATA,   // read data
    output logic [1:0]       RRESP,   // read response
    output logic             RVALID,  // read data valid
    input  wire logic        RREADY,  // read data ready
    input  wire logic        PREOP,   // fieldbus pre-operational pin
    output logic [3:0]       LED_OUT  // strip lines
);
    localparam int NCH = plp_pkg::NCH;
    localparam int SP  = plp_pkg::SEGPIX;
    localparam int AW  = $clog2(NPIX);

    // word decode shared by read and write paths
    function automatic logic dec_ok(input logic [7:0] a);
        // segment words end after the last one, so higher offsets are refused
        dec_ok = (a[1:0] == 2'h0) && ((a <= plp_pkg::A_STATUS) || ((a >= plp_pkg::A_SEG0) &&
                 (a < plp_pkg::A_SEG0 + 8'(4 * plp_pkg::SEGPIX))));
    endfunction : dec_ok

    // byte-lane merge
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            merge[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
        end
    endfunction : merge

    // pixel span test
    function automatic logic in_span(input int i, input logic [11:0] s, input logic [11:0] n);
        in_span = (i >= int'(s)) && (i < int'(s) + int'(n));
    endfunction : in_span

    logic [31:0] pix_r [NCH][NPIX];  // pixel buffer
    logic [31:0] frm_r [NCH][NPIX];  // frame buffer
    logic [31:0] seg_r [SP];         // segment staging words
    logic [31:0] ctrl_r;             // control
    logic [31:0] cmd_r;              // command word
    logic [31:0] color_r;            // fill colour
    logic [1:0]  group_r;            // clocked flag per group
    logic [31:0] set_r;              // per-channel settings
    logic        go_r;               // execute pulse
    logic        awrdy_r, wrdy_r, bvalid_r, arrdy_r, rvalid_r;
    logic [7:0]  awaddr_r;           // held write address
    logic [31:0] wdata_r;            // held write data
    logic [3:0]  wstrb_r;            // held strobes
    logic [1:0]  bresp_r, rresp_r;   // responses
    logic [31:0] rdata_r;            // read data
    logic        preop_s1, preop_s2, preop_s3, preop_r; // pin synchroniser
    logic [31:0] cyc_cnt_r;          // cyclic timer
    logic [3:0]  led_r;              // output lines
    logic [3:0]  busy;               // serializer busy
    logic [3:0]  ser_dat, ser_clk, ser_start;
    logic [AW-1:0] ser_addr [NCH];   // serializer read address

    // write channel: accept address and data in either order
    wire aw_hs  = AWVALID & awrdy_r;
    wire w_hs   = WVALID & wrdy_r;
    wire b_hs   = bvalid_r & BREADY;
    wire wr_go  = ~awrdy_r & ~wrdy_r & ~bvalid_r;
    wire wr_ok  = wr_go & dec_ok(awaddr_r);
    wire [31:0] wmrg_ctrl = merge(ctrl_r, wdata_r, wstrb_r);
    wire [31:0] wmrg_grp  = merge({30'h0, group_r}, wdata_r, wstrb_r);
    wire wr_ctrl    = wr_ok & (awaddr_r == plp_pkg::A_CTRL);
    wire grp_wr     = wr_ok & (awaddr_r == plp_pkg::A_GROUP);
    wire restore_wr = wr_ok & (awaddr_r == plp_pkg::A_RESTORE) & wstrb_r[0] & wdata_r[0];
    wire exec_tgl   = wr_ctrl & (wmrg_ctrl[plp_pkg::CTRL_EXEC] != ctrl_r[plp_pkg::CTRL_EXEC]);
    wire [1:0] grp_chg = wmrg_grp[1:0] ^ group_r;

    // operation decode, valid in the cycle after the toggle
    wire upd_go = go_r & ctrl_r[plp_pkg::CTRL_UPD];
    wire snd_go = go_r & ctrl_r[plp_pkg::CTRL_SEND];
    wire data_go = go_r & ~ctrl_r[plp_pkg::CTRL_UPD] & ~ctrl_r[plp_pkg::CTRL_SEND];
    wire cmd_go = data_go & ~ctrl_r[plp_pkg::CTRL_EXT];
    wire seg_go = data_go & ctrl_r[plp_pkg::CTRL_EXT];
    wire [3:0]  cmd_op  = cmd_r[plp_pkg::CMD_OP +: 4];
    wire [11:0] cmd_idx = cmd_r[plp_pkg::CMD_IDX +: 12];
    wire [11:0] cmd_len = cmd_r[plp_pkg::CMD_LEN +: 12];
    wire cyc_tick = (cyc_cnt_r == 32'(CYCLIC_CYCLES - 1));
    // odd lane of a clocked group carries the clock and has no data of its own
    wire [3:0]  lane_ok = ~{group_r[1], 1'b0, group_r[0], 1'b0};
    wire [3:0]  ch_act  = ctrl_r[plp_pkg::CTRL_MASK +: 4] & lane_ok;
    wire [1:0]  preop_ok_grp = grp_chg; // groups whose function set changes

    // one-cycle execute pulse per toggle of the execute bit
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            go_r <= 1'b0;
        end else begin
            go_r <= exec_tgl;
        end
    end

    // bus handshake state
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            awrdy_r  <= 1'b1;
            wrdy_r   <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r  <= plp_pkg::RESP_OKAY;
            awaddr_r <= 8'h00;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
        end else begin
            if (aw_hs) begin
                awrdy_r  <= 1'b0;
                awaddr_r <= AWADDR;
            end else if (b_hs) begin
                awrdy_r <= 1'b1;
            end
            if (w_hs) begin
                wrdy_r  <= 1'b0;
                wdata_r <= WDATA;
                wstrb_r <= WSTRB;
            end else if (b_hs) begin
                wrdy_r <= 1'b1;
            end
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_ok ? plp_pkg::RESP_OKAY : plp_pkg::RESP_SLVERR;
            end else if (b_hs) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // read channel, answer one cycle after the address
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            arrdy_r  <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= plp_pkg::RESP_OKAY;
        end else if (ARVALID && arrdy_r) begin
            arrdy_r  <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r  <= dec_ok(ARADDR) ? plp_pkg::RESP_OKAY : plp_pkg::RESP_SLVERR;
            case (ARADDR)
                plp_pkg::A_CTRL:   rdata_r <= ctrl_r;
                plp_pkg::A_CMD:    rdata_r <= cmd_r;
                plp_pkg::A_COLOR:  rdata_r <= color_r;
                plp_pkg::A_GROUP:  rdata_r <= {30'h0, group_r};
                plp_pkg::A_SET:    rdata_r <= set_r;
                plp_pkg::A_STATUS: rdata_r <= 32'({preop_r, group_r, busy});
                default: rdata_r <= (dec_ok(ARADDR) && ARADDR >= plp_pkg::A_SEG0) ?
                                    seg_r[ARADDR[4:2]] : 32'h0000_0000;
            endcase
        end else if (rvalid_r && RREADY) begin
            rvalid_r <= 1'b0;
            arrdy_r  <= 1'b1;
        end
    end

    // software registers; group change and restore reload settings
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_r  <= 32'h0000_0000;
            cmd_r   <= 32'h0000_0000;
            color_r <= 32'h0000_0000;
            group_r <= plp_pkg::GROUP_RST;
            set_r   <= plp_pkg::SET_RST;
            for (int k = 0; k < SP; k++) seg_r[k] <= 32'h0000_0000;
        end else if (wr_ok) begin
            case (awaddr_r)
                plp_pkg::A_CTRL:  ctrl_r  <= wmrg_ctrl;
                plp_pkg::A_CMD:   cmd_r   <= merge(cmd_r, wdata_r, wstrb_r);
                plp_pkg::A_COLOR: color_r <= merge(color_r, wdata_r, wstrb_r);
                plp_pkg::A_SET:   set_r   <= merge(set_r, wdata_r, wstrb_r);
                plp_pkg::A_GROUP: begin
                    group_r <= wmrg_grp[1:0];
                    for (int g = 0; g < plp_pkg::NGRP; g++) begin
                        if (preop_ok_grp[g]) begin
                            set_r[g*2 +: 2] <= plp_pkg::SET_RST[g*2 +: 2];
                            set_r[plp_pkg::SET_RGBW + g*2 +: 2] <=
                                plp_pkg::SET_RST[plp_pkg::SET_RGBW + g*2 +: 2];
                        end
                    end
                end
                plp_pkg::A_RESTORE: begin
                    if (restore_wr && preop_r) set_r <= plp_pkg::SET_RST;
                end
                default: begin
                    if (awaddr_r >= plp_pkg::A_SEG0) begin
                        seg_r[awaddr_r[4:2]] <= merge(seg_r[awaddr_r[4:2]], wdata_r, wstrb_r);
                    end
                end
            endcase
        end
    end

    // pixel buffer: commands and segments, all selected data channels in one cycle
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int c = 0; c < NCH; c++) for (int i = 0; i < NPIX; i++) pix_r[c][i] <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                for (int i = 0; i < NPIX; i++) begin
                    if (cmd_go && ch_act[c] && cmd_op == plp_pkg::OP_FILL &&
                        in_span(i, cmd_idx, cmd_len)) begin
                        pix_r[c][i] <= color_r;
                    end else if (cmd_go && ch_act[c] && cmd_op == plp_pkg::OP_CLEAR) begin
                        pix_r[c][i] <= '0;
                    end else if (seg_go && ch_act[c] && int'(cmd_idx) == i / SP) begin
                        pix_r[c][i] <= seg_r[i % SP];
                    end
                end
            end
        end
    end

    // frame buffer: whole copy on update, separate from the pixel side
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int c = 0; c < NCH; c++) for (int i = 0; i < NPIX; i++) frm_r[c][i] <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (upd_go && ch_act[c]) begin
                    for (int i = 0; i < NPIX; i++) frm_r[c][i] <= pix_r[c][i];
                end
            end
        end
    end

    // cyclic resend timer
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            cyc_cnt_r <= 32'h0000_0000;
        end else begin
            cyc_cnt_r <= cyc_tick ? 32'h0000_0000 : cyc_cnt_r + 32'h0000_0001;
        end
    end

    // state pin: three flops, change accepted when the last two agree
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            preop_s1 <= 1'b0;
            preop_s2 <= 1'b0;
            preop_s3 <= 1'b0;
            preop_r  <= 1'b0;
        end else begin
            preop_s1 <= PREOP;
            preop_s2 <= preop_s1;
            preop_s3 <= preop_s2;
            if (preop_s2 == preop_s3) preop_r <= preop_s3;
        end
    end

    // one serializer per channel, started by send or cyclic tick
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        assign ser_start[c] = lane_ok[c] &
            ((snd_go & ch_act[c]) | (cyc_tick & set_r[plp_pkg::SET_CYC + c]));
        plp_led_ser #(.NPIX(NPIX)) u_ser (
            .clk     (MCLK),
            .rst_n   (RESETN),
            .start   (ser_start[c]),
            .rgbw    (set_r[plp_pkg::SET_RGBW + c]),
            .clocked (group_r[c / 2]),
            .px      (frm_r[c][ser_addr[c]]),
            .addr    (ser_addr[c]),
            .dat     (ser_dat[c]),
            .sclk    (ser_clk[c]),
            .busy    (busy[c])
        );
    end

    // output lines: clocked group puts its clock on the odd line
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            led_r <= 4'h0;
        end else begin
            led_r[0] <= ser_dat[0];
            led_r[1] <= group_r[0] ? ser_clk[0] : ser_dat[1];
            led_r[2] <= ser_dat[2];
            led_r[3] <= group_r[1] ? ser_clk[2] : ser_dat[3];
        end
    end

    assign AWREADY = awrdy_r;
    assign WREADY  = wrdy_r;
    assign BVALID  = bvalid_r;
    assign BRESP   = bresp_r;
    assign ARREADY = arrdy_r;
    assign RVALID  = rvalid_r;
    assign RDATA   = rdata_r;
    assign RRESP   = rresp_r;
    assign LED_OUT = led_r;

    AST_EXEC_ONCE: assert property (@(posedge MCLK) disable iff (!RESETN)
        exec_tgl |=> go_r ##1 !go_r) else $error("execute toggle not run once");
    AST_FILL_ALL: assert property (@(posedge MCLK) disable iff (!RESETN)
        cmd_go && ch_act[0] && cmd_op == plp_pkg::OP_FILL && cmd_idx == 12'h000 &&
        int'(cmd_len) >= NPIX |=> pix_r[0][0] == $past(color_r) &&
        pix_r[0][NPIX-1] == $past(color_r)) else $error("fill did not cover buffer");
    AST_SEG: assert property (@(posedge MCLK) disable iff (!RESETN)
        seg_go && ch_act[0] && cmd_idx == 12'h000 |=>
        pix_r[0][SP-1] == $past(seg_r[SP-1])) else $error("segment not written");
    AST_UPDATE: assert property (@(posedge MCLK) disable iff (!RESETN)
        upd_go && ch_act[1] |=> frm_r[1][NPIX-1] == $past(pix_r[1][NPIX-1]))
        else $error("update did not copy");
    AST_SEND_CAUSE: assert property (@(posedge MCLK) disable iff (!RESETN)
        $rose(busy[0]) |-> $past(ser_start[0])) else $error("frame without request");
    AST_CYCLIC: assert property (@(posedge MCLK) disable iff (!RESETN)
        cyc_tick && set_r[plp_pkg::SET_CYC] && !busy[0] |=> busy[0])
        else $error("cyclic frame not started");
    AST_RESTORE: assert property (@(posedge MCLK) disable iff (!RESETN)
        restore_wr && !preop_r |=> set_r == $past(set_r)) else $error("restore outside preop");
    AST_GROUP: assert property (@(posedge MCLK) disable iff (!RESETN)
        grp_wr && grp_chg[0] |=> (set_r & plp_pkg::GRP_SET_MASK) ==
        (plp_pkg::SET_RST & plp_pkg::GRP_SET_MASK)) else $error("group defaults not restored");
    AST_CLK_LINE: assert property (@(posedge MCLK) disable iff (!RESETN)
        group_r[0] && $stable(group_r) |=> LED_OUT[1] == $past(ser_clk[0]))
        else $error("clock line wrong");
    AST_BRESP: assert property (@(posedge MCLK) disable iff (!RESETN)
        wr_go |=> BVALID) else $error("no write response");
endmodule : plp_pipeline

// >>> design/plp_pkg.sv
package plp_pkg;
    // geometry
    localparam int NCH    = 4;       // output channels
    localparam int NGRP   = 2;       // channel pair groups
    localparam int SEGPIX = 8;       // pixels per segment
    localparam int NPIX   = 512;     // pixels per channel
    // register byte addresses
    localparam logic [7:0] A_CTRL    = 8'h00;
    localparam logic [7:0] A_CMD     = 8'h04;
    localparam logic [7:0] A_COLOR   = 8'h08;
    localparam logic [7:0] A_GROUP   = 8'h0C;
    localparam logic [7:0] A_SET     = 8'h10;
    localparam logic [7:0] A_RESTORE = 8'h14;
    localparam logic [7:0] A_STATUS  = 8'h18;
    localparam logic [7:0] A_SEG0    = 8'h20;
    // control fields
    localparam int CTRL_EXEC = 0;    // execute toggle
    localparam int CTRL_UPD  = 1;    // update request
    localparam int CTRL_SEND = 2;    // send request
    localparam int CTRL_EXT  = 3;    // extended (segment) mode
    localparam int CTRL_MASK = 4;    // channel select, 4 bits
    // command fields
    localparam int CMD_OP  = 0;      // opcode, 4 bits
    localparam int CMD_IDX = 4;      // start pixel or segment, 12 bits
    localparam int CMD_LEN = 16;     // pixel count, 12 bits
    localparam logic [3:0] OP_FILL  = 4'h1;
    localparam logic [3:0] OP_CLEAR = 4'h2;
    // settings fields and defaults
    localparam int SET_CYC  = 0;     // cyclic output enable per channel
    localparam int SET_RGBW = 4;     // four colour chips per channel
    localparam logic [31:0] SET_RST      = 32'h0000_000F;
    localparam logic [31:0] GRP_SET_MASK = 32'h0000_0033;
    localparam logic [1:0]  GROUP_RST    = 2'h0;
    // status fields
    localparam int ST_BUSY  = 0;
    localparam int ST_GRP   = 4;
    localparam int ST_PREOP = 6;
    // answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // timing
    localparam int CLK_HZ     = 10_000_000;
    localparam int DATA_HZ    = 800_000;
    localparam int BITS_RGB   = 24;
    localparam int BITS_RGBW  = 32;
    localparam int BIT_CYC    = CLK_HZ / DATA_HZ;
    localparam int T0H_CYC    = BIT_CYC / 3;
    localparam int T1H_CYC    = (BIT_CYC * 2) / 3;
    localparam int RST_US     = 300;
    localparam int RST_CYC    = (RST_US * (CLK_HZ / 1_000_000));
    localparam int CYCLIC_MS  = 250;
    localparam int CYCLIC_CYC = CYCLIC_MS * (CLK_HZ / 1000);
endpackage : plp_pkg

// >>> design/plp_led_ser.sv
`timescale 1ns/10ps
module plp_led_ser #(
    parameter int NPIX    = plp_pkg::NPIX,    // pixels per frame
    parameter int BIT_CYC = plp_pkg::BIT_CYC, // cycles per bit
    parameter int RST_CYC = plp_pkg::RST_CYC, // chip reset gap cycles
    parameter int AW      = $clog2(NPIX)      // pixel address width
) (
    input  wire logic          clk,     // system clock
    input  wire logic          rst_n,   // async reset, low
    input  wire logic          start,   // begin a frame when idle
    input  wire logic          rgbw,    // 32 bits per pixel
    input  wire logic          clocked, // data plus clock line
    input  wire logic [31:0]   px,      // pixel at addr
    output logic      [AW-1:0] addr,    // frame buffer read address
    output logic               dat,     // serial data
    output logic               sclk,    // serial clock
    output logic               busy     // frame in progress
);
    typedef enum logic [1:0] {SER_IDLE, SER_BITS, SER_RST} plp_ser_e;

    plp_ser_e    st_r;        // sequencer state
    logic [4:0]  bit_r;       // bit index, msb first
    logic [11:0] cnt_r;       // cycle counter
    logic        rgbw_r;      // latched colour depth
    logic        clocked_r;   // latched line mode
    logic [AW-1:0] addr_r;    // current pixel
    wire  [4:0]  top_bit = rgbw ? 5'(plp_pkg::BITS_RGBW - 1) : 5'(plp_pkg::BITS_RGB - 1);
    wire  [4:0]  top_lat = rgbw_r ? 5'(plp_pkg::BITS_RGBW - 1) : 5'(plp_pkg::BITS_RGB - 1);
    wire         cur = px[bit_r];
    wire [11:0]  th  = cur ? 12'(plp_pkg::T1H_CYC) : 12'(plp_pkg::T0H_CYC);
    wire         bit_end = (cnt_r == 12'(BIT_CYC - 1));
    wire         in_bits = (st_r == SER_BITS);

    // async mode codes bits as pulse width, clocked mode as level plus clock
    assign dat  = in_bits & (clocked_r ? cur : (cnt_r < th));
    assign sclk = in_bits & clocked_r & (cnt_r >= 12'(BIT_CYC / 2));
    assign busy = (st_r != SER_IDLE);
    assign addr = addr_r;

    // frame sequencer: all pixels, then the reset gap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r      <= SER_IDLE;
            bit_r     <= 5'h00;
            cnt_r     <= 12'h000;
            rgbw_r    <= 1'b0;
            clocked_r <= 1'b0;
            addr_r    <= '0;
        end else begin
            case (st_r)
                SER_IDLE: begin
                    cnt_r <= 12'h000;
                    if (start) begin
                        st_r      <= SER_BITS;
                        addr_r    <= '0;
                        bit_r     <= top_bit;
                        rgbw_r    <= rgbw;
                        clocked_r <= clocked;
                    end
                end
                SER_BITS: begin
                    cnt_r <= bit_end ? 12'h000 : cnt_r + 12'h001;
                    if (bit_end && bit_r == 5'h00) begin
                        bit_r <= top_lat;
                        if (addr_r == AW'(NPIX - 1)) begin
                            st_r <= SER_RST;
                        end else begin
                            addr_r <= addr_r + AW'(1);
                        end
                    end else if (bit_end) begin
                        bit_r <= bit_r - 5'h01;
                    end
                end
                SER_RST: begin
                    cnt_r <= cnt_r + 12'h001;
                    if (cnt_r == 12'(RST_CYC - 1)) begin
                        st_r <= SER_IDLE;
                    end
                end
                default: st_r <= SER_IDLE;
            endcase
        end
    end
endmodule : plp_led_ser

// >>> tb/plp_strip_model.sv
`timescale 1ns/10ps
// strip end: counts bits of a frame, a long low gap closes the frame
module plp_strip_model (
    input  wire logic clk,    // system clock
    input  wire logic din,    // strip data line
    output int        bits,   // bits in last frame
    output int        hi,     // high cycles of its first bit
    output int        frames  // frames seen
);
    int   cnt;  // rising edges so far
    int   gap;  // low cycles in a row
    int   w;    // first pulse width
    logic d_r;  // line one cycle ago
    // edge count, first pulse width, frame close after 1000 low cycles
    always @(posedge clk) begin
        d_r <= din;
        if (din) gap <= 0;
        else gap <= gap + 1;
        if (din && !d_r) cnt <= cnt + 1;
        if (din && (cnt == 0 || (cnt == 1 && d_r))) w <= w + 1;
        if (gap == 1000 && cnt != 0) begin
            bits   <= cnt;
            hi     <= w;
            frames <= frames + 1;
            cnt    <= 0;
            w      <= 0;
        end
    end
endmodule : plp_strip_model

// >>> tb/plp_pipeline_bench.sv
`timescale 1ns/10ps
module plp_pipeline_bench;
    logic MCLK = 0, RESETN = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0;
    logic RREADY = 0, PREOP = 0, AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [7:0]  AWADDR = 0, ARADDR = 0;
    logic [31:0] WDATA = 0, RDATA, q;
    logic [3:0]  WSTRB = 4'hF, LED_OUT;
    logic [1:0]  BRESP, RRESP, r;
    int          failures, checks, bits, hi, frames, f;
    int          cbits, chi, cframes; // clock line model results
    always #50 MCLK = ~MCLK;
    plp_pipeline #(.NPIX(16), .CYCLIC_CYCLES(20000)) dut_u (.MCLK(MCLK), .RESETN(RESETN),
        .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
        .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(RREADY), .PREOP(PREOP), .LED_OUT(LED_OUT));
    plp_strip_model strip_u (.clk(MCLK), .din(LED_OUT[0]), .bits(bits), .hi(hi),
        .frames(frames));
    plp_strip_model clk_u (.clk(MCLK), .din(LED_OUT[1]), .bits(cbits), .hi(chi),
        .frames(cframes));
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk
    // bus write, each channel released at its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        {AWVALID, WVALID, BREADY} <= 3'h7;
        AWADDR <= a;
        WDATA <= d;
        do begin
            @(posedge MCLK);
            if (AWREADY) AWVALID <= 1'h0;
            if (WREADY) WVALID <= 1'h0;
            r = BRESP;
        end while (!BVALID);
        BREADY <= 1'h0;
    endtask : wr
    // bus read into q and r
    task automatic rd(input logic [7:0] a);
        @(posedge MCLK);
        {ARVALID, RREADY} <= 2'h3;
        ARADDR <= a;
        do begin
            @(posedge MCLK);
            if (ARREADY) ARVALID <= 1'h0;
            {q, r} = {RDATA, RRESP};
        end while (!RVALID);
        RREADY <= 1'h0;
    endtask : rd
    // wait for the next frame, at most n cycles
    task automatic idle(input int n);
        f = frames;
        for (int i = 0; i < n && frames == f; i++) @(posedge MCLK);
    endtask : idle
    // defaults, unmapped access, restore and group change
    task automatic t_regs;
        rd(plp_pkg::A_SET);
        chk(q, 32'h0000_000F, "set default");
        rd(8'h1C);
        chk(r, plp_pkg::RESP_SLVERR, "unmapped");
        rd(8'h40);
        chk(r, plp_pkg::RESP_SLVERR, "above segment words");
        wr(8'h1C, 32'h0000_0000);
        chk(r, plp_pkg::RESP_SLVERR, "write unmapped");
        wr(plp_pkg::A_SET, 32'h0000_0000);
        wr(plp_pkg::A_RESTORE, 32'h0000_0001);
        rd(plp_pkg::A_SET);
        chk(q, 32'h0000_0000, "restore outside preop");
        @(posedge MCLK);
        PREOP <= 1'h1;
        repeat (6) @(posedge MCLK);
        wr(plp_pkg::A_RESTORE, 32'h0000_0001);
        rd(plp_pkg::A_SET);
        chk(q, 32'h0000_000F, "restore in preop");
        wr(plp_pkg::A_SET, 32'h0000_0000);
        wr(plp_pkg::A_GROUP, 32'h0000_0001);
        rd(plp_pkg::A_SET);
        chk(q, 32'h0000_0003, "group change");
        wr(plp_pkg::A_GROUP, 32'h0000_0000);
        wr(plp_pkg::A_SET, 32'h0000_0000);
        idle(9000);
        $display("regs done");
    endtask : t_regs
    // fill, update, send once, then cyclic resend
    task automatic t_send;
        wr(plp_pkg::A_COLOR, 32'h00FF_0000);
        wr(plp_pkg::A_CMD, 32'h0010_0001);
        wr(plp_pkg::A_CTRL, 32'h0000_0011);
        wr(plp_pkg::A_CTRL, 32'h0000_0016);
        idle(30000);
        chk(bits, 384, "bit count");
        chk(hi, 8, "first bit high");
        idle(22000);
        chk(frames - f, 0, "no unrequested frame");
        wr(plp_pkg::A_SET, 32'h0000_0001);
        idle(22000);
        chk(frames - f, 1, "cyclic resend");
        $display("send done");
    endtask : t_send
    // one extended segment over the red fill, then update and send
    task automatic t_seg;
        wr(plp_pkg::A_SET, 32'h0000_0000);
        repeat (2500) @(posedge MCLK);
        rd(plp_pkg::A_STATUS);
        chk(q, 32'h0000_0040, "status idle in preop");
        wr(plp_pkg::A_SEG0, 32'h0000_0000);
        wr(plp_pkg::A_CMD, 32'h0000_0000);
        wr(plp_pkg::A_CTRL, 32'h0000_0019);
        wr(plp_pkg::A_CTRL, 32'h0000_0016);
        idle(30000);
        chk(hi, 4, "segment pixel sent");
        chk(bits, 384, "segment frame bits");
        $display("segment done");
    endtask : t_seg
    // group 0 clocked: data level on line 0, clock on line 1
    task automatic t_clk;
        wr(plp_pkg::A_GROUP, 32'h0000_0001);
        wr(plp_pkg::A_SET, 32'h0000_0000);
        repeat (2500) @(posedge MCLK);
        wr(plp_pkg::A_CTRL, 32'h0000_0017);
        idle(30000);
        repeat (300) @(posedge MCLK);
        chk(bits, 8, "data level edges");
        chk(cbits, 384, "clock pulses");
        chk(chi, 6, "clock high cycles");
        chk(cframes, 1, "one clocked frame");
        $display("clocked done");
    endtask : t_clk
    // verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (4) @(posedge MCLK);
        RESETN <= 1'h1;
        t_regs;
        t_send;
        t_seg;
        t_clk;
        report_and_stop;
    end
    // hang guard, well above the expected run
    initial begin
        #9_000_000;
        failures++;
        report_and_stop;
    end
endmodule : plp_pipeline_bench
